//--- rtl/fhr_pkg.sv
// fhr_pkg: constants and carrier types for the fieldbus holding register slave
// assumes a byte-wide query/response stream from the link layer outside this block
package fhr_pkg;
	// ----------------------------------------
	// message limits and function codes
	// ----------------------------------------
	localparam int MAX_QUERY_LEN = 252;
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_PRESET_MULTI = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	// ----------------------------------------
	// shared memory and node address
	// ----------------------------------------
	localparam int DPM_BYTES = 1024;
	localparam int DPM_WORDS = DPM_BYTES / 2;
	localparam int DPM_AW = 9;
	localparam logic [6:0] NODE_ADDR_BASE = 7'h01;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} fhr_byte_t;

	typedef struct packed {
		logic [DPM_AW-1:0] addr;
		logic [15:0] data;
		logic we;
	} fhr_dpm_req_t;
endpackage

//--- rtl/fhr_slave.sv
// fhr_slave: slave command handler, decodes queries and answers from shared memory
// assumes the link layer delivers whole queries as byte streams and accepts responses
//
// Function
// - slave only answers; never starts a transfer
// - first byte function code selects action
// - parser sized for 252-byte queries
// - code 03 reads 16-bit holding registers
// - code 16 presets consecutive holding registers
// - register addresses in messages are zero-based
// - dual-port memory is only data path
// - node address is switch sum plus one
// - switch weights 1..32, OFF contributes weight
`timescale 1ns/100ps
`default_nettype none
module fhr_slave #(
	parameter int MAX_LEN = fhr_pkg::MAX_QUERY_LEN
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [5:0] addr_switch_on_in,
	output logic [6:0] node_addr_out,
	input wire logic rx_valid_in,
	input wire fhr_pkg::fhr_byte_t rx_byte_in,
	output logic rx_ready_out,
	output logic tx_valid_out,
	output fhr_pkg::fhr_byte_t tx_byte_out,
	input wire logic tx_ready_in,
	input wire logic ctl_we_in,
	input wire logic [fhr_pkg::DPM_AW-1:0] ctl_addr_in,
	input wire logic [15:0] ctl_wdata_in,
	output logic [15:0] ctl_rdata_out,
	output logic busy_out
);
	typedef enum {ST_FUNC, ST_HDR, ST_DATA, ST_DRAIN, ST_RESP_HDR, ST_RESP_DATA} fhr_state_t;

	// ----------------------------------------
	// dual-port memory
	// ----------------------------------------
	logic [15:0] dpm [fhr_pkg::DPM_WORDS];
	fhr_pkg::fhr_dpm_req_t net_req;
	logic [15:0] net_rdata;

	always_ff @(posedge mclk_in) begin
		if (net_req.we)
			dpm[net_req.addr] <= net_req.data;
		if (ctl_we_in)
			dpm[ctl_addr_in] <= ctl_wdata_in;
		net_rdata <= dpm[net_req.addr];
		ctl_rdata_out <= dpm[ctl_addr_in];
	end

	// ----------------------------------------
	// node address
	// ----------------------------------------
	// switch ON reads as 1 on its pin; ON contributes zero
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			node_addr_out <= fhr_pkg::NODE_ADDR_BASE;
		else
			node_addr_out <= {1'b0, ~addr_switch_on_in} + fhr_pkg::NODE_ADDR_BASE;
	end

	// ----------------------------------------
	// query parser and responder
	// ----------------------------------------
	fhr_state_t state, next_state;
	logic [7:0] func, next_func;
	logic [15:0] start, next_start;
	logic [15:0] count, next_count;
	logic [7:0] hdr_idx, next_hdr_idx;
	logic [7:0] len, next_len;
	logic [15:0] idx, next_idx;
	logic [7:0] hi_byte, next_hi_byte;
	logic bad, next_bad;
	fhr_pkg::fhr_byte_t tx, next_tx;
	logic tx_v, next_tx_v;

	function automatic logic range_ok(input logic [15:0] s, input logic [15:0] n);
		logic [16:0] e;
		e = {1'b0, s} + {1'b0, n};
		range_ok = (n != 16'h0000) && (e <= 17'(fhr_pkg::DPM_WORDS));
	endfunction

	// a last answer byte still waiting keeps the next query out
	assign rx_ready_out = ((state == ST_FUNC) || (state == ST_HDR)
		|| (state == ST_DATA) || (state == ST_DRAIN)) && !tx_v;
	assign tx_valid_out = tx_v;
	assign tx_byte_out = tx;
	assign busy_out = (state != ST_FUNC) || tx_v;

	always_comb begin
		next_state = state;
		next_func = func;
		next_start = start;
		next_count = count;
		next_hdr_idx = hdr_idx;
		next_len = len;
		next_idx = idx;
		next_hi_byte = hi_byte;
		next_bad = bad;
		next_tx = tx;
		next_tx_v = tx_v;
		net_req = '{addr: start[fhr_pkg::DPM_AW-1:0] + idx[fhr_pkg::DPM_AW-1:0],
			data: fhr_pkg::RESET_WORD, we: 1'b0};
		if (tx_v && tx_ready_in)
			next_tx_v = 1'b0;
		case (state)
			ST_FUNC: begin
				if (rx_valid_in && rx_ready_out) begin
					next_func = rx_byte_in.data;
					next_hdr_idx = 8'h00;
					next_len = 8'h01;
					next_idx = 16'h0000;
					next_bad = !(rx_byte_in.data == fhr_pkg::FC_READ_HOLD
						|| rx_byte_in.data == fhr_pkg::FC_PRESET_MULTI);
					if (rx_byte_in.last)
						next_state = ST_RESP_HDR;
					else if (next_bad)
						next_state = ST_DRAIN;
					else
						next_state = ST_HDR;
				end
			end
			ST_HDR: begin
				if (rx_valid_in) begin
					next_len = len + 8'h01;
					next_hdr_idx = hdr_idx + 8'h01;
					case (hdr_idx)
						8'h00: next_start[15:8] = rx_byte_in.data;
						8'h01: next_start[7:0] = rx_byte_in.data;
						8'h02: next_count[15:8] = rx_byte_in.data;
						8'h03: next_count[7:0] = rx_byte_in.data;
						default: ;
					endcase
					// preset carries a byte count after the word count
					if ((func == fhr_pkg::FC_READ_HOLD && hdr_idx == 8'h03)
						|| (func == fhr_pkg::FC_PRESET_MULTI && hdr_idx == 8'h04)) begin
						next_bad = !range_ok(start, next_count);
						next_state = rx_byte_in.last ? ST_RESP_HDR
							: ((func == fhr_pkg::FC_PRESET_MULTI && !next_bad) ? ST_DATA : ST_DRAIN);
					end else if (rx_byte_in.last) begin
						next_bad = 1'b1;
						next_state = ST_RESP_HDR;
					end
				end
			end
			ST_DATA: begin
				if (rx_valid_in) begin
					next_len = len + 8'h01;
					next_hdr_idx = hdr_idx + 8'h01;
					if (hdr_idx[0]) begin
						next_hi_byte = rx_byte_in.data;
					end else if (idx < count) begin
						net_req.data = {hi_byte, rx_byte_in.data};
						net_req.we = 1'b1;
						next_idx = idx + 16'h0001;
					end
					if (rx_byte_in.last || len >= 8'(MAX_LEN - 1))
						next_state = rx_byte_in.last ? ST_RESP_HDR : ST_DRAIN;
				end
			end
			ST_DRAIN: begin
				// overlong or refused query: swallow to end of message
				if (rx_valid_in && rx_byte_in.last)
					next_state = ST_RESP_HDR;
			end
			ST_RESP_HDR: begin
				if (!tx_v || tx_ready_in) begin
					next_tx_v = 1'b1;
					next_tx.last = 1'b0;
					case (hdr_idx)
						8'hf0: next_tx.data = bad ? (func | fhr_pkg::EXC_FLAG) : func;
						8'hf1: begin
							if (bad) begin
								next_tx.data = (func == fhr_pkg::FC_READ_HOLD
									|| func == fhr_pkg::FC_PRESET_MULTI)
									? fhr_pkg::EXC_ILLEGAL_ADDR : fhr_pkg::EXC_ILLEGAL_FUNC;
								next_tx.last = 1'b1;
							end else if (func == fhr_pkg::FC_READ_HOLD)
								next_tx.data = 8'(count << 1);
							else
								next_tx.data = start[15:8];
						end
						8'hf2: next_tx.data = start[7:0];
						8'hf3: next_tx.data = count[15:8];
						default: begin
							next_tx.data = count[7:0];
							next_tx.last = 1'b1;
						end
					endcase
					next_hdr_idx = hdr_idx + 8'h01;
					if (next_tx.last) begin
						next_state = ST_FUNC;
					end else if (hdr_idx == 8'hf1 && func == fhr_pkg::FC_READ_HOLD) begin
						next_idx = 16'h0000;
						next_hdr_idx = 8'h00;
						next_state = ST_RESP_DATA;
					end
				end else begin
					next_tx_v = tx_v;
				end
				if (hdr_idx < 8'hf0)
					next_hdr_idx = 8'hf0;
				if (hdr_idx < 8'hf0)
					next_tx_v = tx_v && !tx_ready_in;
				if (hdr_idx < 8'hf0)
					next_state = ST_RESP_HDR;
			end
			ST_RESP_DATA: begin
				// phase 0 addresses memory, 1 sends high byte, 2 sends low byte
				if (hdr_idx == 8'h00) begin
					next_hdr_idx = 8'h01;
				end else if (!tx_v || tx_ready_in) begin
					next_tx_v = 1'b1;
					next_tx.data = (hdr_idx == 8'h01) ? net_rdata[15:8] : net_rdata[7:0];
					next_tx.last = (hdr_idx == 8'h02) && (idx + 16'h0001 == count);
					if (hdr_idx == 8'h01) begin
						next_hdr_idx = 8'h02;
					end else begin
						next_hdr_idx = 8'h00;
						next_idx = idx + 16'h0001;
						if (next_tx.last)
							next_state = ST_FUNC;
					end
				end
			end
			default: next_state = ST_FUNC;
		endcase
		// long presets leave hdr_idx anywhere; restart the answer header
		if (next_state == ST_RESP_HDR && state != ST_RESP_HDR)
			next_hdr_idx = 8'h00;
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_FUNC;
			func <= 8'h00;
			start <= 16'h0000;
			count <= 16'h0000;
			hdr_idx <= 8'h00;
			len <= 8'h00;
			idx <= 16'h0000;
			hi_byte <= 8'h00;
			bad <= 1'b0;
			tx <= '0;
			tx_v <= 1'b0;
		end else begin
			state <= next_state;
			func <= next_func;
			start <= next_start;
			count <= next_count;
			hdr_idx <= next_hdr_idx;
			len <= next_len;
			idx <= next_idx;
			hi_byte <= next_hi_byte;
			bad <= next_bad;
			tx <= next_tx;
			tx_v <= next_tx_v;
		end
	end
endmodule
`default_nettype wire

//--- bench/fhr_slave_checker.sv
// fhr_slave_checker: port assertions for the holding register slave
// assumes a bind onto fhr_slave, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module fhr_slave_checker (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [5:0] addr_switch_on_in,
	input wire logic [6:0] node_addr_out,
	input wire logic rx_valid_in,
	input wire fhr_pkg::fhr_byte_t rx_byte_in,
	input wire logic rx_ready_out,
	input wire logic tx_valid_out,
	input wire fhr_pkg::fhr_byte_t tx_byte_out,
	input wire logic tx_ready_in,
	input wire logic ctl_we_in,
	input wire logic [8:0] ctl_addr_in,
	input wire logic [15:0] ctl_wdata_in,
	input wire logic [15:0] ctl_rdata_out,
	input wire logic busy_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	logic [7:0] func;
	logic known;
	logic await_rsp;
	assign known = func == fhr_pkg::FC_READ_HOLD || func == fhr_pkg::FC_PRESET_MULTI;
	// function byte is the one taken while idle
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			func <= 8'h00;
		else if (!busy_out && rx_valid_in && rx_ready_out)
			func <= rx_byte_in.data;
	end
	// open from a query's end until the first answer byte is taken;
	// valid may drop between words, so a rise alone is not the first byte
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			await_rsp <= 1'b0;
		else if (rx_valid_in && rx_ready_out && rx_byte_in.last)
			await_rsp <= 1'b1;
		else if (tx_valid_out && tx_ready_in)
			await_rsp <= 1'b0;
	end
	sequence q_end;
		rx_valid_in && rx_ready_out && rx_byte_in.last;
	endsequence
	sequence rsp_start;
		$rose(tx_valid_out) && await_rsp;
	endsequence
	node_addr_a: assert property ($past(rst_n_in) |->
		node_addr_out == {1'b0, ~$past(addr_switch_on_in)} + 7'h01) else $error("node address");
	quiet_rx_a: assert property (tx_valid_out |-> !rx_ready_out) else $error("rx open");
	no_unasked_a: assert property (rsp_start |-> $past(busy_out)) else $error("unasked");
	tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=>
		tx_valid_out && $stable(tx_byte_out)) else $error("tx byte dropped");
	idle_a: assert property (!busy_out |-> rx_ready_out && !tx_valid_out) else $error("idle");
	answer_a: assert property (q_end |-> ##[1:8] tx_valid_out) else $error("no answer");
	echo_a: assert property (rsp_start |-> tx_byte_out.data[6:0] == func[6:0])
		else $error("function echo");
	exc_code_a: assert property (rsp_start ##0 !known |->
		tx_byte_out.data == (func | fhr_pkg::EXC_FLAG)) else $error("exception code");
	mem_read_a: assert property (ctl_we_in ##1 (!ctl_we_in && $stable(ctl_addr_in)) |=>
		ctl_rdata_out == $past(ctl_wdata_in, 2)) else $error("memory read");
endmodule
`default_nettype wire

//--- bench/fhr_plc_model.sv
// fhr_plc_model: bus master stand-in that sends queries and gathers answers
// assumes byte handshakes taken on the rising edge of mclk_in
`timescale 1ns/100ps
`default_nettype none
module fhr_plc_model (
	input wire logic mclk_in,
	input wire logic rx_ready_in,
	output logic rx_valid_out,
	output fhr_pkg::fhr_byte_t rx_byte_out,
	input wire logic tx_valid_in,
	input wire fhr_pkg::fhr_byte_t tx_byte_in,
	output logic tx_ready_out
);
	logic slow = 1'b0;
	logic [7:0] resp[$];
	initial begin
		rx_valid_out = 1'b0;
		rx_byte_out = 9'h000;
		tx_ready_out = 1'b1;
	end
	task automatic query(input logic [7:0] q[$]);
		int n;
		resp = {};
		foreach (q[i]) begin
			@(posedge mclk_in);
			#1;
			rx_valid_out = 1'b1;
			rx_byte_out = {q[i], i == q.size() - 1};
			while (!rx_ready_in) begin
				@(posedge mclk_in);
				#1;
			end
		end
		@(posedge mclk_in);
		#1;
		rx_valid_out = 1'b0;
		// released line shows no stale byte
		rx_byte_out = ~rx_byte_out;
		for (n = 0; n < 60; n++) begin
			tx_ready_out = slow ? ~tx_ready_out : 1'b1;
			if (tx_valid_in && tx_ready_out)
				resp.push_back(tx_byte_in.data);
			if (tx_valid_in && tx_ready_out && tx_byte_in.last)
				break;
			@(posedge mclk_in);
			#1;
		end
		@(posedge mclk_in);
		#1;
		tx_ready_out = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- bench/fhr_slave_tb.sv
// fhr_slave_tb: self-checking bench for the holding register slave
// assumes fhr_plc_model plays the bus master
`timescale 1ns/100ps
`default_nettype none
module fhr_slave_tb;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [5:0] addr_switch_on_in = 6'h3f;
	logic rx_valid_in, rx_ready_out, tx_valid_out, tx_ready_in, busy_out;
	logic ctl_we_in = 1'b0;
	logic [8:0] ctl_addr_in = 9'h000;
	logic [15:0] ctl_wdata_in = 16'h0000;
	logic [15:0] ctl_rdata_out;
	logic [6:0] node_addr_out;
	fhr_pkg::fhr_byte_t rx_byte_in, tx_byte_out;
	int failures = 0;
	int tests_run = 0;
	initial forever #5 mclk_in = ~mclk_in;
	fhr_slave i_fhr_slave (.mclk_in, .rst_n_in, .addr_switch_on_in, .node_addr_out,
		.rx_valid_in, .rx_byte_in, .rx_ready_out, .tx_valid_out, .tx_byte_out, .tx_ready_in,
		.ctl_we_in, .ctl_addr_in, .ctl_wdata_in, .ctl_rdata_out, .busy_out);
	fhr_plc_model i_fhr_plc_model (.mclk_in, .rx_ready_in(rx_ready_out),
		.rx_valid_out(rx_valid_in), .rx_byte_out(rx_byte_in), .tx_valid_in(tx_valid_out),
		.tx_byte_in(tx_byte_out), .tx_ready_out(tx_ready_in));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic [7:0] q[$], input logic [7:0] e[$]);
		i_fhr_plc_model.query(q);
		check(16'(i_fhr_plc_model.resp.size()), 16'(e.size()));
		foreach (e[i]) check({8'h00, i_fhr_plc_model.resp[i]}, {8'h00, e[i]});
	endtask
	task automatic ctl_rd(input logic [8:0] a, input logic [15:0] e);
		@(posedge mclk_in);
		#1;
		ctl_addr_in = a;
		@(posedge mclk_in);
		#1;
		check(ctl_rdata_out, e);
	endtask
	task automatic t_switches();
		logic [5:0] on_set[3] = '{6'h26, 6'h3f, 6'h00};
		logic [6:0] exp[3] = '{7'h1a, 7'h01, 7'h40};
		foreach (on_set[i]) begin
			addr_switch_on_in = on_set[i];
			repeat (2) @(posedge mclk_in);
			#1;
			check({9'h000, node_addr_out}, {9'h000, exp[i]});
		end
	endtask
	task automatic t_zero_based();
		ctl_we_in = 1'b1;
		ctl_wdata_in = 16'h5a5a;
		@(posedge mclk_in);
		#1;
		ctl_we_in = 1'b0;
		run({8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h03, 8'h02, 8'h5a, 8'h5a});
	endtask
	task automatic t_preset_read();
		run({8'h10, 8'h00, 8'h05, 8'h00, 8'h02, 8'h04, 8'hab, 8'hcd, 8'h12, 8'h34},
			{8'h10, 8'h00, 8'h05, 8'h00, 8'h02});
		ctl_rd(9'h005, 16'habcd);
		ctl_rd(9'h006, 16'h1234);
		i_fhr_plc_model.slow = 1'b1;
		run({8'h03, 8'h00, 8'h05, 8'h00, 8'h02},
			{8'h03, 8'h04, 8'hab, 8'hcd, 8'h12, 8'h34});
		i_fhr_plc_model.slow = 1'b0;
	endtask
	task automatic t_refused();
		run({8'h04, 8'h00, 8'h05, 8'h00, 8'h01}, {8'h84, 8'h01});
		run({8'h06, 8'h00, 8'h05, 8'hff, 8'hff}, {8'h86, 8'h01});
		ctl_rd(9'h005, 16'habcd);
		run({8'h03, 8'h01, 8'hff, 8'h00, 8'h02}, {8'h83, 8'h02});
	endtask
	// 256-byte preset: bytes past 252 must not reach memory
	task automatic t_long();
		logic [7:0] q[$];
		q = {8'h10, 8'h00, 8'h10, 8'h00, 8'h7d, 8'hfa};
		for (int i = 0; i < 250; i++)
			q.push_back(8'(i));
		ctl_addr_in = 9'h08b;
		ctl_wdata_in = 16'h0bad;
		ctl_we_in = 1'b1;
		@(posedge mclk_in);
		#1;
		ctl_we_in = 1'b0;
		run(q, {8'h10, 8'h00, 8'h10, 8'h00, 8'h7d});
		ctl_rd(9'h08a, 16'hf4f5);
		ctl_rd(9'h08b, 16'h0bad);
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge mclk_in);
		#1;
		rst_n_in = 1'b1;
		t_switches();
		t_zero_based();
		t_preset_read();
		t_refused();
		t_long();
		summarize();
	end
	initial begin
		#50us;
		failures++;
		summarize();
	end
endmodule
bind fhr_slave fhr_slave_checker i_fhr_slave_checker (.mclk_in, .rst_n_in, .addr_switch_on_in,
	.node_addr_out, .rx_valid_in, .rx_byte_in, .rx_ready_out, .tx_valid_out, .tx_byte_out,
	.tx_ready_in, .ctl_we_in, .ctl_addr_in, .ctl_wdata_in, .ctl_rdata_out, .busy_out);
`default_nettype wire
